// ### hdl/lti_ctrl.sv
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
module lti_ctrl
  import lti_pkg::*;
#(
  parameter int DW = 10,
  parameter int SW = 16
) (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  input wire logic [DW-1:0] i_link_in_a,
  input wire logic [DW-1:0] i_link_in_b,
  output logic [DW-1:0] o_loopthru_out,
  output logic o_loopthru_drive_en,
  output logic o_loopthru_tx_pwr_up,
  input wire logic i_frame_start,
  input wire logic i_line_start,
  input wire logic i_pix_valid,
  input wire logic [SW-1:0] i_h_active,
  input wire logic [SW-1:0] i_v_active,
  output logic o_test_image_on,
  output logic o_pix_valid,
  output logic [7:0] o_pix_r,
  output logic [7:0] o_pix_g,
  output logic [7:0] o_pix_b
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [7:0] regs_reg [NREG];
  logic [NREG-1:0] hit;
  logic status_hit;
  logic [7:0] status;
  logic [7:0] rd_mux;
  logic [7:0] rdata_reg;
  logic drive_on;
  logic [1:0] pick_b;
  logic pick_a;
  logic tx_pwdn;
  logic image_on;
  logic [3:0] image_pick;
  logic autoscroll;
  logic invert;
  logic [7:0] frame_cnt_reg;
  logic [7:0] frame_cnt_next;
  logic [3:0] scroll_reg;
  logic [3:0] scroll_next;
  logic frame_due;
  logic use_b;
  logic [DW-1:0] sel_data;
  logic [DW-1:0] lt_out_reg;
  logic [7:0] h_level;
  logic [7:0] v_level;
  logic [23:0] rgb;
  logic [23:0] rgb_reg;
  logic pv_reg;
  lti_ctl_if ctl ();

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  for (genvar gi = 0; gi < NREG; gi++) begin : g_reg
    assign hit[gi] = (i_reg_addr == REG_ADDR[gi]);
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
        regs_reg[gi] <= REG_RST[gi];
      end else if (i_reg_wr && hit[gi]) begin
        regs_reg[gi] <= i_reg_wdata;
      end
    end
  end

  assign status_hit = (i_reg_addr == ADDR_STATUS);
  assign status = {image_on, autoscroll, 2'b00, scroll_reg};

  always_comb begin
    rd_mux = status_hit ? status : 8'h00;
    for (int i = 0; i < NREG; i++) begin
      rd_mux = rd_mux | (hit[i] ? regs_reg[i] : 8'h00);
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= i_reg_rd ? rd_mux : 8'h00;
    end
  end

  assign o_reg_rdata = rdata_reg;

  // ----------------------------------------
  // Field decode
  // ----------------------------------------
  assign drive_on = regs_reg[IDX_OUT_EN][BIT_DRIVE_ON];
  assign pick_b = regs_reg[IDX_STEER][BIT_PICK_B_LO+1:BIT_PICK_B_LO];
  assign pick_a = regs_reg[IDX_STEER][BIT_PICK_A];
  assign tx_pwdn = regs_reg[IDX_PWR][BIT_TX_PWDN];
  assign image_on = regs_reg[IDX_PG_CTL][BIT_IMAGE_ON];
  assign image_pick = regs_reg[IDX_PG_CTL][BIT_PICK_LO+3:BIT_PICK_LO];
  assign autoscroll = regs_reg[IDX_PG_CFG][BIT_ASCRL];
  assign invert = regs_reg[IDX_PG_CFG][BIT_INVERT];

  // ----------------------------------------
  // Loop-through path
  // ----------------------------------------
  assign use_b = (pick_b == PICK_B_B) ||
    ((pick_b != PICK_B_A) && pick_a);
  assign sel_data = use_b ? i_link_in_b : i_link_in_a;
  assign o_loopthru_drive_en = drive_on && !tx_pwdn;
  assign o_loopthru_tx_pwr_up = !tx_pwdn;

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      lt_out_reg <= '0;
    end else begin
      lt_out_reg <= o_loopthru_drive_en ? sel_data : '0;
    end
  end

  assign o_loopthru_out = lt_out_reg;

  // ----------------------------------------
  // Auto-scroll sequencer
  // ----------------------------------------
  assign frame_due = (frame_cnt_reg + 8'h01) >= regs_reg[IDX_FRAME_T];
  assign frame_cnt_next = !autoscroll ? 8'h00 :
    !i_frame_start ? frame_cnt_reg :
    frame_due ? 8'h00 : frame_cnt_reg + 8'h01;
  assign scroll_next = !autoscroll ? image_pick :
    !(i_frame_start && frame_due) ? scroll_reg :
    (scroll_reg >= PAT_CUSTOM || scroll_reg == PAT_RSVD0) ? PAT_WHITE :
    scroll_reg + 4'h1;

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      frame_cnt_reg <= 8'h00;
      scroll_reg <= PAT_WHITE;
    end else begin
      frame_cnt_reg <= frame_cnt_next;
      scroll_reg <= scroll_next;
    end
  end

  // ----------------------------------------
  // Ramp position trackers
  // ----------------------------------------
  lti_ramp #(
    .SW(SW)
  ) u_h_ramp (
    .i_clk_sys(i_clk_sys),
    .i_reset_n(i_reset_n),
    .i_start(i_line_start),
    .i_step(i_pix_valid),
    .i_span(i_h_active),
    .o_level(h_level)
  );

  lti_ramp #(
    .SW(SW)
  ) u_v_ramp (
    .i_clk_sys(i_clk_sys),
    .i_reset_n(i_reset_n),
    .i_start(i_frame_start),
    .i_step(i_line_start),
    .i_span(i_v_active),
    .o_level(v_level)
  );

  // ----------------------------------------
  // Pattern selection
  // ----------------------------------------
  assign ctl.code = autoscroll ? scroll_reg : image_pick;
  assign ctl.invert = invert;
  assign ctl.bars = regs_reg[IDX_PG_CTL][BIT_BARS];
  assign ctl.compl = regs_reg[IDX_PG_CTL][BIT_COMPL];
  assign ctl.band_rev = regs_reg[IDX_PG_CTL][BIT_BAND_REV];
  assign ctl.cust = {regs_reg[IDX_CUST_R], regs_reg[IDX_CUST_G], regs_reg[IDX_CUST_B]};
  assign ctl.h_level = h_level;
  assign ctl.v_level = v_level;

  lti_pix_color u_color (
    .c(ctl),
    .o_rgb(rgb)
  );

  // ----------------------------------------
  // Pixel output
  // ----------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pv_reg <= 1'b0;
      rgb_reg <= 24'h000000;
    end else begin
      pv_reg <= image_on && i_pix_valid;
      rgb_reg <= (image_on && i_pix_valid) ? rgb : 24'h000000;
    end
  end

  assign o_test_image_on = image_on;
  assign o_pix_valid = pv_reg;
  assign o_pix_r = rgb_reg[23:16];
  assign o_pix_g = rgb_reg[15:8];
  assign o_pix_b = rgb_reg[7:0];

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_reset_n);

  logic plain_fixed;
  assign plain_fixed = image_on && !autoscroll && !ctl.compl && !ctl.bars;

  property p_drive_off;
    !drive_on |=> o_loopthru_out == '0;
  endproperty
  a_drive_off: assert property (p_drive_off)
    else $error("loop-through driven while disabled");

  property p_pick_b_route;
    (drive_on && !tx_pwdn && pick_b == PICK_B_B) |=>
      o_loopthru_out == $past(i_link_in_b);
  endproperty
  a_pick_b_route: assert property (p_pick_b_route)
    else $error("port pick b code 10 did not route link_in_b");

  property p_pick_a_route;
    (drive_on && !tx_pwdn && pick_b != PICK_B_B && !pick_a) |=>
      o_loopthru_out == $past(i_link_in_a);
  endproperty
  a_pick_a_route: assert property (p_pick_a_route)
    else $error("port pick a did not route link_in_a");

  property p_pwdn;
    (i_reg_wr && i_reg_addr == ADDR_PWR && i_reg_wdata[BIT_TX_PWDN]) |=>
      !o_loopthru_tx_pwr_up && !o_loopthru_drive_en;
  endproperty
  a_pwdn: assert property (p_pwdn)
    else $error("transmitter not powered down after write");

  property p_gen_off;
    !image_on |=> !o_pix_valid && rgb_reg == 24'h000000;
  endproperty
  a_gen_off: assert property (p_gen_off)
    else $error("pixels produced while generator off");

  property p_white;
    (plain_fixed && i_pix_valid && !invert && image_pick == PAT_WHITE) |=>
      o_pix_valid && {o_pix_r, o_pix_g, o_pix_b} == 24'hFFFFFF;
  endproperty
  a_white: assert property (p_white)
    else $error("white fill wrong");

  property p_inv_black;
    (plain_fixed && i_pix_valid && invert && image_pick == PAT_BLACK) |=>
      {o_pix_r, o_pix_g, o_pix_b} == 24'hFFFFFF;
  endproperty
  a_inv_black: assert property (p_inv_black)
    else $error("inverted black fill wrong");

  property p_compl_band;
    (image_on && ctl.compl && !ctl.band_rev && !invert && i_pix_valid &&
      h_level[7:6] == 2'b00) |=> {o_pix_r, o_pix_g, o_pix_b} == 24'hFFFF00;
  endproperty
  a_compl_band: assert property (p_compl_band)
    else $error("first compliance band not yellow");

  property p_bar_two;
    (image_on && !ctl.compl && ctl.bars && !invert && i_pix_valid &&
      h_level[7:5] == 3'b010) |=> {o_pix_r, o_pix_g, o_pix_b} == 24'h00FFFF;
  endproperty
  a_bar_two: assert property (p_bar_two)
    else $error("third colour bar not cyan");

  property p_scroll_step;
    ($past(autoscroll) && autoscroll && $changed(scroll_reg)) |->
      $past(i_frame_start);
  endproperty
  a_scroll_step: assert property (p_scroll_step)
    else $error("scroll pattern moved without a frame start");

  property p_store;
    (i_reg_wr && i_reg_addr == ADDR_OUT_EN) ##1 (i_reg_rd && i_reg_addr == ADDR_OUT_EN)
      |=> o_reg_rdata == $past(i_reg_wdata, 2);
  endproperty
  a_store: assert property (p_store)
    else $error("register did not read back as written");

  c_loopthru_b: cover property (drive_on && !tx_pwdn && pick_b == PICK_B_B);
  c_scroll: cover property (autoscroll && i_frame_start && frame_due);
  c_bars: cover property (image_on && ctl.bars && i_pix_valid);
  c_compl_rev: cover property (image_on && ctl.compl && ctl.band_rev && i_pix_valid);
endmodule

// ### inc/lti_pkg.sv
// How it works
// - Loop-through pair is driven only while loopthru_drive_on is 1; reset leaves it off.
// - loopthru_port_pick_b code 01 routes link_in_a, code 10 routes link_in_b.
// - loopthru_port_pick_a 0 selects link_in_a, 1 selects link_in_b, while loopthru_port_pick_b is 00 or 11.
// - loopthru_tx_powerdown 0 powers the transmitter up, 1 powers it down; reset 0.
// - Test image generator runs only while test_image_on is 1.
// - Codes 0001-0101 give white, black, red, green, blue fills, complemented when inverted.
// - Codes 0110-1001 give horizontal ramps from black to white, red, green, blue.
// - Codes 1010-1101 give vertical ramps from black to white, red, green, blue.
// - Code 1110 gives the custom level colour; 0000 and 1111 are reserved.
// - Ramps spread evenly over active pixels of a line or active lines of a frame.
// - test_image_pick is ignored while image_autoscroll is on.
// - Autoscroll steps to the next pattern every scroll_frame_count frames, else holds.
// - compliance_image_on shows the compliance image and ignores test_image_pick.
// - bar_image_on shows eight bars: white, yellow, cyan, green, magenta, red, blue, black.
// - Band order is yellow, cyan, blue, red; reversed it is blue, cyan, yellow, red.
// - image_invert complements every colour component of the generated image.
package lti_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam int NREG = 9;
  localparam logic [7:0] ADDR_OUT_EN = 8'h56;
  localparam logic [7:0] ADDR_STEER = 8'h57;
  localparam logic [7:0] ADDR_PWR = 8'h63;
  localparam logic [7:0] ADDR_PG_CTL = 8'h64;
  localparam logic [7:0] ADDR_PG_CFG = 8'h65;
  localparam logic [7:0] ADDR_FRAME_T = 8'h6A;
  localparam logic [7:0] ADDR_CUST_R = 8'h6B;
  localparam logic [7:0] ADDR_CUST_G = 8'h6C;
  localparam logic [7:0] ADDR_CUST_B = 8'h6D;
  localparam logic [7:0] ADDR_STATUS = 8'h6E;
  localparam int IDX_OUT_EN = 0;
  localparam int IDX_STEER = 1;
  localparam int IDX_PWR = 2;
  localparam int IDX_PG_CTL = 3;
  localparam int IDX_PG_CFG = 4;
  localparam int IDX_FRAME_T = 5;
  localparam int IDX_CUST_R = 6;
  localparam int IDX_CUST_G = 7;
  localparam int IDX_CUST_B = 8;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_PG_CTL = 8'h10;
  localparam logic [7:0] RST_FRAME_T = 8'h01;
  localparam logic [7:0] REG_ADDR [NREG] = '{ADDR_OUT_EN, ADDR_STEER, ADDR_PWR,
    ADDR_PG_CTL, ADDR_PG_CFG, ADDR_FRAME_T, ADDR_CUST_R, ADDR_CUST_G, ADDR_CUST_B};
  localparam logic [7:0] REG_RST [NREG] = '{RST_ZERO, RST_ZERO, RST_ZERO,
    RST_PG_CTL, RST_ZERO, RST_FRAME_T, RST_ZERO, RST_ZERO, RST_ZERO};
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int BIT_DRIVE_ON = 3;
  localparam int BIT_PICK_B_LO = 1;
  localparam int BIT_PICK_A = 7;
  localparam int BIT_TX_PWDN = 0;
  localparam int BIT_IMAGE_ON = 0;
  localparam int BIT_BAND_REV = 1;
  localparam int BIT_BARS = 2;
  localparam int BIT_COMPL = 3;
  localparam int BIT_PICK_LO = 4;
  localparam int BIT_ASCRL = 0;
  localparam int BIT_INVERT = 1;
  localparam int BIT_ST_ON = 7;
  localparam int BIT_ST_ASCRL = 6;
  localparam logic [1:0] PICK_B_A = 2'b01;
  localparam logic [1:0] PICK_B_B = 2'b10;
  // ----------------------------------------
  // Patterns and colours
  // ----------------------------------------
  typedef enum logic [3:0] {
    PAT_RSVD0 = 4'b0000, PAT_WHITE = 4'b0001, PAT_BLACK = 4'b0010,
    PAT_RED = 4'b0011, PAT_GREEN = 4'b0100, PAT_BLUE = 4'b0101,
    PAT_HR_W = 4'b0110, PAT_HR_R = 4'b0111, PAT_HR_G = 4'b1000,
    PAT_HR_B = 4'b1001, PAT_VR_W = 4'b1010, PAT_VR_R = 4'b1011,
    PAT_VR_G = 4'b1100, PAT_VR_B = 4'b1101, PAT_CUSTOM = 4'b1110,
    PAT_RSVD15 = 4'b1111
  } lti_pat_e;
  localparam logic [2:0] M_WHITE = 3'b111;
  localparam logic [2:0] M_YELLOW = 3'b110;
  localparam logic [2:0] M_CYAN = 3'b011;
  localparam logic [2:0] M_GREEN = 3'b010;
  localparam logic [2:0] M_MAGENTA = 3'b101;
  localparam logic [2:0] M_RED = 3'b100;
  localparam logic [2:0] M_BLUE = 3'b001;
  localparam logic [2:0] M_BLACK = 3'b000;
  localparam logic [2:0] BAR_MASK [8] = '{M_WHITE, M_YELLOW, M_CYAN, M_GREEN,
    M_MAGENTA, M_RED, M_BLUE, M_BLACK};
  localparam logic [2:0] BAND_MASK [4] = '{M_YELLOW, M_CYAN, M_BLUE, M_RED};
  localparam logic [2:0] BAND_MASK_REV [4] = '{M_BLUE, M_CYAN, M_YELLOW, M_RED};
  localparam logic [8:0] RAMP_STEPS = 9'h100;
endpackage

// ### inc/lti_ctl_if.sv
`timescale 1ns/1ps
interface lti_ctl_if;
  logic [3:0] code;
  logic invert;
  logic bars;
  logic compl;
  logic band_rev;
  logic [23:0] cust;
  logic [7:0] h_level;
  logic [7:0] v_level;
  modport src (output code, invert, bars, compl, band_rev, cust, h_level, v_level);
  modport dst (input code, invert, bars, compl, band_rev, cust, h_level, v_level);
endinterface

// ### hdl/lti_ramp.sv
`timescale 1ns/1ps
module lti_ramp
  import lti_pkg::*;
#(
  parameter int SW = 16
) (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic i_start,
  input wire logic i_step,
  input wire logic [SW-1:0] i_span,
  output logic [7:0] o_level
);
  logic [SW:0] acc_reg;
  logic [7:0] lvl_reg;
  logic [SW:0] acc_sum;
  logic wrap;
  // ----------------------------------------
  // Even spread over the span
  // ----------------------------------------
  assign acc_sum = acc_reg + (SW+1)'(RAMP_STEPS);
  assign wrap = acc_sum >= {1'b0, i_span};
  assign o_level = lvl_reg;
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      acc_reg <= '0;
      lvl_reg <= 8'h00;
    end else if (i_start) begin
      acc_reg <= '0;
      lvl_reg <= 8'h00;
    end else if (i_step && lvl_reg != 8'hFF) begin
      acc_reg <= wrap ? acc_sum - {1'b0, i_span} : acc_sum;
      lvl_reg <= wrap ? lvl_reg + 8'h01 : lvl_reg;
    end
  end
endmodule

// ### hdl/lti_pix_color.sv
`timescale 1ns/1ps
module lti_pix_color
  import lti_pkg::*;
(
  lti_ctl_if.dst c,
  output logic [23:0] o_rgb
);
  function automatic logic [23:0] fill(input logic [2:0] m, input logic [7:0] l);
    fill = {m[2] ? l : 8'h00, m[1] ? l : 8'h00, m[0] ? l : 8'h00};
  endfunction
  logic [23:0] base;
  logic [23:0] chosen;
  logic [2:0] band_m;
  // ----------------------------------------
  // Fixed pattern decode
  // ----------------------------------------
  always_comb begin
    case (c.code)
      PAT_WHITE: base = fill(M_WHITE, 8'hFF);
      PAT_BLACK: base = fill(M_BLACK, 8'hFF);
      PAT_RED: base = fill(M_RED, 8'hFF);
      PAT_GREEN: base = fill(M_GREEN, 8'hFF);
      PAT_BLUE: base = fill(M_BLUE, 8'hFF);
      PAT_HR_W: base = fill(M_WHITE, c.h_level);
      PAT_HR_R: base = fill(M_RED, c.h_level);
      PAT_HR_G: base = fill(M_GREEN, c.h_level);
      PAT_HR_B: base = fill(M_BLUE, c.h_level);
      PAT_VR_W: base = fill(M_WHITE, c.v_level);
      PAT_VR_R: base = fill(M_RED, c.v_level);
      PAT_VR_G: base = fill(M_GREEN, c.v_level);
      PAT_VR_B: base = fill(M_BLUE, c.v_level);
      PAT_CUSTOM: base = c.cust;
      default: base = 24'h000000;
    endcase
  end
  // ----------------------------------------
  // Priority and inversion
  // ----------------------------------------
  assign band_m = c.band_rev ? BAND_MASK_REV[c.h_level[7:6]] : BAND_MASK[c.h_level[7:6]];
  assign chosen = c.compl ? fill(band_m, 8'hFF) :
    c.bars ? fill(BAR_MASK[c.h_level[7:5]], 8'hFF) : base;
  assign o_rgb = chosen ^ {24{c.invert}};
endmodule

// ### verif/lti_lt_rx.sv
`timescale 1ns/1ps
module lti_lt_rx #(
  parameter int DW = 10
) (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic i_drive_en,
  input wire logic [DW-1:0] i_rx_data,
  output logic [DW-1:0] o_link_a,
  output logic [DW-1:0] o_link_b,
  output logic [DW-1:0] o_exp_a,
  output logic [DW-1:0] o_exp_b,
  output logic o_rx_err
);
  logic en_q;
  // ----------------------------------------
  // Link sources, changing every cycle
  // ----------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_link_a <= '0;
      o_link_b <= '1;
      o_exp_a <= '0;
      o_exp_b <= '0;
    end else begin
      o_link_a <= o_link_a + 1'b1;
      o_link_b <= o_link_b - 2'd3;
      o_exp_a <= o_link_a;
      o_exp_b <= o_link_b;
    end
  end
  // ----------------------------------------
  // Receiver: pair quiet one cycle after disable
  // ----------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      en_q <= 1'b0;
      o_rx_err <= 1'b0;
    end else begin
      en_q <= i_drive_en;
      if (!en_q && i_rx_data != '0) begin
        o_rx_err <= 1'b1;
      end
    end
  end
endmodule

// ### verif/lti_ctrl_tb.sv
`timescale 1ns/1ps
module lti_ctrl_tb;
  import lti_pkg::*;
  localparam int DW = 10;
  localparam int SW = 16;
  localparam logic [2:0] FILL [6] = '{M_BLACK, M_WHITE, M_BLACK, M_RED, M_GREEN, M_BLUE};
  localparam logic [2:0] HMASK [4] = '{M_WHITE, M_RED, M_GREEN, M_BLUE};
  logic i_clk_sys = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_reg_wr = 1'b0;
  logic i_reg_rd = 1'b0;
  logic [7:0] i_reg_addr = 8'h00;
  logic [7:0] i_reg_wdata = 8'h00;
  logic i_frame_start = 1'b0;
  logic i_line_start = 1'b0;
  logic i_pix_valid = 1'b0;
  logic [SW-1:0] i_h_active = 16'h0100;
  logic [SW-1:0] i_v_active = 16'h0100;
  logic [7:0] o_reg_rdata, o_pix_r, o_pix_g, o_pix_b;
  logic [DW-1:0] link_a, link_b, exp_a, exp_b, o_loopthru_out;
  logic o_loopthru_drive_en, o_loopthru_tx_pwr_up, o_test_image_on, o_pix_valid, rx_err;
  int failures = 0;
  int n_tests = 0;

  always #50 i_clk_sys = ~i_clk_sys;

  lti_ctrl #(.DW(DW), .SW(SW)) u_dut (
    .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .o_reg_rdata(o_reg_rdata), .i_link_in_a(link_a), .i_link_in_b(link_b),
    .o_loopthru_out(o_loopthru_out), .o_loopthru_drive_en(o_loopthru_drive_en),
    .o_loopthru_tx_pwr_up(o_loopthru_tx_pwr_up), .i_frame_start(i_frame_start),
    .i_line_start(i_line_start), .i_pix_valid(i_pix_valid), .i_h_active(i_h_active),
    .i_v_active(i_v_active), .o_test_image_on(o_test_image_on), .o_pix_valid(o_pix_valid),
    .o_pix_r(o_pix_r), .o_pix_g(o_pix_g), .o_pix_b(o_pix_b));

  lti_lt_rx #(.DW(DW)) u_rx (
    .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_drive_en(o_loopthru_drive_en),
    .i_rx_data(o_loopthru_out), .o_link_a(link_a), .o_link_b(link_b),
    .o_exp_a(exp_a), .o_exp_b(exp_b), .o_rx_err(rx_err));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("Checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  function automatic logic [23:0] m2c(input logic [2:0] m);
    return {{8{m[2]}}, {8{m[1]}}, {8{m[0]}}};
  endfunction

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_wr <= 1'b1;
    @(posedge i_clk_sys);
    i_reg_wr <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_clk_sys);
    i_reg_addr <= a;
    i_reg_rd <= 1'b1;
    @(posedge i_clk_sys);
    i_reg_rd <= 1'b0;
    #1;
    chk(o_reg_rdata, e);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask

  task automatic line(input logic fs, input int n, input int k, input logic ev,
                      input logic [23:0] e);
    @(posedge i_clk_sys);
    i_frame_start <= fs;
    i_line_start <= 1'b1;
    @(posedge i_clk_sys);
    i_frame_start <= 1'b0;
    i_line_start <= 1'b0;
    i_pix_valid <= 1'b1;
    for (int i = 0; i < n; i++) begin
      @(posedge i_clk_sys);
      if (i == n - 1) i_pix_valid <= 1'b0;
      #1;
      if (i == k) begin
        chk(o_pix_valid, ev);
        chk({o_pix_r, o_pix_g, o_pix_b}, e);
      end
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    for (int i = 0; i < NREG; i++) rchk(REG_ADDR[i], REG_RST[i]);
    rchk(8'h70, 8'h00);
    for (int i = 0; i < NREG; i++) wr(REG_ADDR[i], 8'hA5);
    for (int i = 0; i < NREG; i++) rchk(REG_ADDR[i], 8'hA5);
    for (int i = NREG - 1; i >= 0; i--) wr(REG_ADDR[i], REG_RST[i]);
    @(posedge i_clk_sys);
    i_reg_addr <= ADDR_OUT_EN;
    i_reg_wdata <= 8'h52;
    i_reg_wr <= 1'b1;
    @(posedge i_clk_sys);
    i_reg_wr <= 1'b0;
    i_reg_rd <= 1'b1;
    @(posedge i_clk_sys);
    i_reg_rd <= 1'b0;
    #1;
    chk(o_reg_rdata, 8'h52);
    wr(ADDR_STATUS, 8'hFF);
    rchk(ADDR_STATUS, 8'h01);
    $display("t_regs done");
  endtask

  task automatic t_loop();
    wr(ADDR_STEER, 8'h02);
    cyc(3);
    chk({o_loopthru_drive_en, o_loopthru_out}, 0);
    wr(ADDR_OUT_EN, 8'hF7);
    cyc(3);
    chk({o_loopthru_drive_en, o_loopthru_out}, 0);
    wr(ADDR_OUT_EN, 8'h08);
    cyc(2);
    chk({o_loopthru_drive_en, o_loopthru_out}, {1'b1, exp_a});
    wr(ADDR_STEER, 8'h84);
    cyc(2);
    chk(o_loopthru_out, exp_b);
    wr(ADDR_PWR, 8'h01);
    cyc(2);
    chk({o_loopthru_tx_pwr_up, o_loopthru_drive_en, o_loopthru_out}, 0);
    wr(ADDR_PWR, 8'h00);
    cyc(2);
    chk({o_loopthru_tx_pwr_up, o_loopthru_out}, {1'b1, exp_b});
    wr(ADDR_OUT_EN, 8'h00);
    $display("t_loop done");
  endtask

  task automatic t_fill();
    wr(ADDR_PWR, 8'h01);
    line(1'b1, 4, 2, 1'b0, 24'h000000);
    for (int v = 0; v < 2; v++) begin
      wr(ADDR_PG_CFG, {6'h00, v[0], 1'b0});
      for (int c = 0; c < 6; c++) begin
        wr(ADDR_PG_CTL, {c[3:0], 4'h1});
        line(1'b1, 4, 2, 1'b1, m2c(FILL[c]) ^ {24{v[0]}});
      end
      wr(ADDR_PG_CTL, 8'hF1);
      line(1'b1, 4, 2, 1'b1, {24{v[0]}});
      wr(ADDR_CUST_R, 8'h12);
      wr(ADDR_CUST_G, 8'h34);
      wr(ADDR_CUST_B, 8'h56);
      wr(ADDR_PG_CTL, 8'hE1);
      #1;
      chk(o_test_image_on, 1'b1);
      line(1'b1, 4, 2, 1'b1, 24'h123456 ^ {24{v[0]}});
    end
    $display("t_fill done");
  endtask

  task automatic t_ramp();
    for (int v = 0; v < 2; v++) begin
      wr(ADDR_PG_CFG, {6'h00, v[0], 1'b0});
      for (int c = 0; c < 4; c++) begin
        wr(ADDR_PG_CTL, {4'h6 + c[3:0], 4'h1});
        line(1'b1, 256, 100, 1'b1, (m2c(HMASK[c]) & 24'h646464) ^ {24{v[0]}});
        wr(ADDR_PG_CTL, {4'hA + c[3:0], 4'h1});
        for (int m = 0; m < 3; m++) begin
          line(m == 0, 8, 3, 1'b1, (m2c(HMASK[c]) & {3{m[7:0]}}) ^ {24{v[0]}});
        end
      end
    end
    wr(ADDR_PG_CFG, 8'h00);
    wr(ADDR_PG_CTL, 8'h61);
    line(1'b1, 256, 255, 1'b1, 24'hFFFFFF);
    $display("t_ramp done");
  endtask

  task automatic t_bars();
    wr(ADDR_PG_CTL, 8'h15);
    for (int k = 0; k < 8; k++) line(1'b1, 256, 32 * k + 16, 1'b1, m2c(BAR_MASK[k]));
    for (int r = 0; r < 2; r++) begin
      wr(ADDR_PG_CTL, {4'h1, 2'b11, r[0], 1'b1});
      for (int k = 0; k < 4; k++) begin
        line(1'b1, 256, 64 * k + 32, 1'b1,
             m2c(r[0] ? BAND_MASK_REV[k] : BAND_MASK[k]));
      end
    end
    $display("t_bars done");
  endtask

  task automatic t_scroll();
    wr(ADDR_FRAME_T, 8'h01);
    wr(ADDR_PG_CTL, 8'hE1);
    wr(ADDR_PG_CFG, 8'h01);
    rchk(ADDR_STATUS, 8'hCE);
    line(1'b1, 4, 2, 1'b1, 24'hFFFFFF);
    rchk(ADDR_STATUS, 8'hC1);
    wr(ADDR_PG_CTL, 8'h31);
    line(1'b0, 4, 2, 1'b1, 24'hFFFFFF);
    rchk(ADDR_STATUS, 8'hC1);
    wr(ADDR_FRAME_T, 8'h02);
    line(1'b1, 4, 2, 1'b1, 24'hFFFFFF);
    line(1'b1, 4, 2, 1'b1, 24'h000000);
    rchk(ADDR_STATUS, 8'hC2);
    wr(ADDR_PG_CFG, 8'h00);
    wr(ADDR_PG_CTL, 8'h10);
    wr(ADDR_PWR, 8'h00);
    $display("t_scroll done");
  endtask

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge i_clk_sys);
    i_reset_n <= 1'b1;
    t_regs();
    t_loop();
    t_fill();
    t_ramp();
    t_bars();
    t_scroll();
    chk(rx_err, 1'b0);
    test_done();
  end

  initial begin
    #5000000;
    failures++;
    test_done();
  end
endmodule
